// ---- src/glf_gpio_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "glf_consts.svh"

// What this block does
// - four lines, picked by index, each with its own settings
// - each line is set as input or output
// - per-line inverter flips the line's logic sense
// - single-line readback gives one for high, zero for low
// - packed readback puts line n level in bit n
// - deglitch and debounce widths in microseconds, per line and kind
// - deglitch reports a new level only after it lasted the width
// - debounce passes first edge, then blocks changes for its time
// - deglitch stage feeds the debounce stage
// - output lines drive a selected source signal
// - exposure and frame-trigger-wait sources go through the line's inverter like every other source
// - one soft bit picked by index is written high or low
// - packed soft word writes and reads all soft bits at once
// - read-only circuit type per line: tri-state, opto, open-drain
// - only line 2 has the auxiliary supply enable
// - soft bit index picks which bit a single write updates

module glf_gpio_top
#(
  parameter int SPAN_W = `GLF_SPAN_W
)
(
  input  wire logic                  sys_clk,
  input  wire logic                  sys_rst,
  input  wire logic                  sys_ce,
  input  wire glf_pkg::glf_reg_req_t reg_req,
  output logic [31:0]                reg_rdata,
  input  wire glf_pkg::glf_ext_src_t ext_src,
  input  wire logic [3:0]            line_in,
  output logic [3:0]                 line_out,
  output logic [3:0]                 line_oe,
  output logic                       aux_supply_on
);
  import glf_pkg::*;

  localparam int NL = `GLF_NUM_LINES;

  typedef struct packed {
    logic [1:0]                   pin_sel;
    logic [NL-1:0]                dir;
    logic [NL-1:0]                inv;
    glf_src_t [NL-1:0]            src;
    logic                         aux;
    logic                         kind;
    logic [NL-1:0][1:0][SPAN_W-1:0] span;
    logic [1:0]                   usr_sel;
    logic [NL-1:0]                usr;
    logic [NL-1:0]                sync1;
    logic [NL-1:0]                sync2;
    logic [NL-1:0]                drv;
    logic [31:0]                  rdata;
  } glf_top_st_t;

  glf_top_st_t   st_reg;
  glf_top_st_t   st_next;
  logic [NL-1:0] filt;
  logic [NL-1:0] levels;

  // fixed wiring of the connector: lines 0 and 1 isolated, 2 open-drain
  function automatic glf_circuit_t fmt_of(input logic [1:0] idx);
    case (idx)
      2'h0:    return GLF_FMT_OPTO;
      2'h1:    return GLF_FMT_OPTO;
      2'h2:    return GLF_FMT_ODRN;
      default: return GLF_FMT_TRI;
    endcase
  endfunction

  function automatic logic src_value(
    input glf_src_t     s,
    input logic [3:0]   lv,
    input logic [3:0]   ub,
    input glf_ext_src_t ex
  );
    case (s)
      GLF_SRC_LINE0: return lv[0];
      GLF_SRC_LINE1: return lv[1];
      GLF_SRC_LINE2: return lv[2];
      GLF_SRC_LINE3: return lv[3];
      GLF_SRC_USR0:  return ub[0];
      GLF_SRC_USR1:  return ub[1];
      GLF_SRC_USR2:  return ub[2];
      GLF_SRC_USR3:  return ub[3];
      GLF_SRC_CTR0:  return ex.ctr_active[0];
      GLF_SRC_CTR1:  return ex.ctr_active[1];
      GLF_SRC_LB0:   return ex.lb_out[0];
      GLF_SRC_LB1:   return ex.lb_out[1];
      GLF_SRC_EXPO:  return ex.expo_active;
      GLF_SRC_FTW:   return ex.frame_trig_wait;
      default:       return 1'b0;
    endcase
  endfunction

  genvar g;
  generate
    for (g = 0; g < NL; g++)
    begin : g_flt
      glf_line_filter #(
        .SPAN_W (SPAN_W)
      ) u_flt (
        .sys_clk    (sys_clk),
        .sys_rst    (sys_rst),
        .sys_ce     (sys_ce),
        .raw_level  (st_reg.sync2[g]),
        .dg_span_us (st_reg.span[g][`GLF_KIND_DEGLITCH]),
        .db_span_us (st_reg.span[g][`GLF_KIND_DEBOUNCE]),
        .filt_level (filt[g])
      );
    end
  endgenerate

  // inputs report the filtered level after inversion, outputs what they drive
  always_comb
  begin
    for (int i = 0; i < NL; i++)
      levels[i] = st_reg.dir[i] ? st_reg.drv[i]
                                : filt[i] ^ st_reg.inv[i];
  end

  always_comb
  begin
    st_next = st_reg;
    if (sys_ce)
    begin
      st_next.sync1 = line_in;
      st_next.sync2 = st_reg.sync1;
      for (int i = 0; i < NL; i++)
        st_next.drv[i] = src_value(st_reg.src[i], levels, st_reg.usr,
                                   ext_src) ^ st_reg.inv[i];
      st_next.rdata = '0;
      if (reg_req.wr)
      begin
        case (reg_req.addr)
          `GLF_OFS_PIN_SEL:
            st_next.pin_sel = reg_req.wdata[1:0];
          `GLF_OFS_PIN_CFG:
          begin
            st_next.dir[st_reg.pin_sel] = reg_req.wdata[`GLF_CFG_DIR];
            st_next.inv[st_reg.pin_sel] = reg_req.wdata[`GLF_CFG_INV];
            st_next.src[st_reg.pin_sel] = glf_src_t'(
              reg_req.wdata[`GLF_CFG_SRC_MSB:`GLF_CFG_SRC_LSB]);
            if (st_reg.pin_sel == `GLF_AUX_LINE)
              st_next.aux = reg_req.wdata[`GLF_CFG_AUX];
          end
          `GLF_OFS_FLT_KIND:
            st_next.kind = reg_req.wdata[0];
          `GLF_OFS_FLT_SPAN:
            st_next.span[st_reg.pin_sel][st_reg.kind] =
              reg_req.wdata[SPAN_W-1:0];
          `GLF_OFS_USR_SEL:
            st_next.usr_sel = reg_req.wdata[1:0];
          `GLF_OFS_USR_VAL:
            st_next.usr[st_reg.usr_sel] = reg_req.wdata[0];
          `GLF_OFS_USR_ALL:
            st_next.usr = reg_req.wdata[NL-1:0];
          default:
            st_next.usr = st_reg.usr;
        endcase
      end
      if (reg_req.rd)
      begin
        case (reg_req.addr)
          `GLF_OFS_PIN_SEL:
            st_next.rdata = {30'h0, st_reg.pin_sel};
          `GLF_OFS_PIN_CFG:
            st_next.rdata = {24'h0, st_reg.src[st_reg.pin_sel], 1'b0,
                             st_reg.aux && st_reg.pin_sel == `GLF_AUX_LINE,
                             st_reg.inv[st_reg.pin_sel],
                             st_reg.dir[st_reg.pin_sel]};
          `GLF_OFS_FLT_KIND:
            st_next.rdata = {31'h0, st_reg.kind};
          `GLF_OFS_FLT_SPAN:
            st_next.rdata = 32'(st_reg.span[st_reg.pin_sel][st_reg.kind]);
          `GLF_OFS_LEVEL:
            st_next.rdata = {31'h0, levels[st_reg.pin_sel]};
          `GLF_OFS_LEVELS:
            st_next.rdata = {28'h0, levels};
          `GLF_OFS_USR_SEL:
            st_next.rdata = {30'h0, st_reg.usr_sel};
          `GLF_OFS_USR_VAL:
            st_next.rdata = {31'h0, st_reg.usr[st_reg.usr_sel]};
          `GLF_OFS_USR_ALL:
            st_next.rdata = {28'h0, st_reg.usr};
          `GLF_OFS_FMT:
            st_next.rdata = {30'h0, fmt_of(st_reg.pin_sel)};
          default:
            st_next.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      st_reg       <= '0;
      for (int i = 0; i < NL; i++)
        st_reg.src[i] <= glf_src_t'(`GLF_SRC_RST);
      st_reg.sync1 <= `GLF_SYNC_RST;
      st_reg.sync2 <= `GLF_SYNC_RST;
    end
    else
      st_reg <= st_next;
  end

  // open-drain line only pulls low; while it feeds the supply it is released
  always_comb
  begin
    for (int i = 0; i < NL; i++)
    begin
      if (fmt_of(2'(i)) == GLF_FMT_ODRN)
      begin
        line_out[i] = 1'b0;
        line_oe[i]  = st_reg.dir[i] && !st_reg.drv[i] &&
                      !(st_reg.aux && 2'(i) == `GLF_AUX_LINE);
      end
      else
      begin
        line_out[i] = st_reg.drv[i];
        line_oe[i]  = st_reg.dir[i];
      end
    end
  end

  assign aux_supply_on = st_reg.aux;
  assign reg_rdata     = st_reg.rdata;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_line_sel_hold:
    assert property (sys_ce && reg_req.wr &&
                     reg_req.addr == `GLF_OFS_PIN_SEL |=>
                     st_reg.pin_sel == $past(reg_req.wdata[1:0]))
    else $error("line index not taken");

  a_input_no_drive:
    assert property (!st_reg.dir[1] |-> !line_oe[1] ##0 !line_oe[3] ||
                     st_reg.dir[3])
    else $error("input line is driven");

  a_output_invert:
    assert property (sys_ce && st_reg.src[1] == GLF_SRC_USR0 |=>
                     st_reg.drv[1] == ($past(st_reg.usr[0]) ^
                                       $past(st_reg.inv[1])))
    else $error("output sense not flipped by inverter");

  a_single_level:
    assert property (sys_ce && reg_req.rd &&
                     reg_req.addr == `GLF_OFS_LEVEL |=>
                     reg_rdata == {31'h0, $past(levels[st_reg.pin_sel])})
    else $error("single line readback wrong");

  a_packed_levels:
    assert property (sys_ce && reg_req.rd &&
                     reg_req.addr == `GLF_OFS_LEVELS |=>
                     reg_rdata == {28'h0, $past(levels)} ##1
                     (reg_rdata == '0 || !$past(sys_ce) || $past(reg_req.rd)))
    else $error("packed readback wrong or held too long");

  a_soft_bit_write:
    assert property (sys_ce && reg_req.wr &&
                     reg_req.addr == `GLF_OFS_USR_VAL |=>
                     st_reg.usr[$past(st_reg.usr_sel)] ==
                     $past(reg_req.wdata[0]))
    else $error("picked soft bit not written");

  a_soft_all_write:
    assert property (sys_ce && reg_req.wr &&
                     reg_req.addr == `GLF_OFS_USR_ALL |=>
                     st_reg.usr == $past(reg_req.wdata[3:0]))
    else $error("packed soft word not written");

  a_aux_line_only:
    assert property (sys_ce && reg_req.wr &&
                     reg_req.addr == `GLF_OFS_PIN_CFG &&
                     st_reg.pin_sel != `GLF_AUX_LINE |=>
                     $stable(aux_supply_on))
    else $error("supply enable moved from another line");

  a_format_read:
    assert property (sys_ce && reg_req.rd && reg_req.addr == `GLF_OFS_FMT &&
                     st_reg.pin_sel == 2'h2 |=>
                     reg_rdata == {30'h0, GLF_FMT_ODRN})
    else $error("circuit type of line 2 wrong");

endmodule
`default_nettype wire

// ---- src/glf_consts.svh ----
`ifndef GLF_CONSTS_SVH
`define GLF_CONSTS_SVH

`define GLF_NUM_LINES     4
`define GLF_LINE_W        2
`define GLF_SPAN_W        16
`define GLF_CLK_MHZ       40
`define GLF_SYNC_RST      4'h0

`define GLF_OFS_PIN_SEL   8'h00
`define GLF_OFS_PIN_CFG   8'h04
`define GLF_OFS_FLT_KIND  8'h08
`define GLF_OFS_FLT_SPAN  8'h0c
`define GLF_OFS_LEVEL     8'h10
`define GLF_OFS_LEVELS    8'h14
`define GLF_OFS_USR_SEL   8'h18
`define GLF_OFS_USR_VAL   8'h1c
`define GLF_OFS_USR_ALL   8'h20
`define GLF_OFS_FMT       8'h24

`define GLF_CFG_DIR       0
`define GLF_CFG_INV       1
`define GLF_CFG_AUX       2
`define GLF_CFG_SRC_LSB   4
`define GLF_CFG_SRC_MSB   7

`define GLF_KIND_DEGLITCH 1'b0
`define GLF_KIND_DEBOUNCE 1'b1
`define GLF_AUX_LINE      2'h2
`define GLF_SRC_RST       4'hf

`endif

// ---- src/glf_pkg.sv ----
package glf_pkg;

  typedef enum logic [3:0] {
    GLF_SRC_LINE0 = 4'h0,
    GLF_SRC_LINE1 = 4'h1,
    GLF_SRC_LINE2 = 4'h2,
    GLF_SRC_LINE3 = 4'h3,
    GLF_SRC_USR0  = 4'h4,
    GLF_SRC_USR1  = 4'h5,
    GLF_SRC_USR2  = 4'h6,
    GLF_SRC_USR3  = 4'h7,
    GLF_SRC_CTR0  = 4'h8,
    GLF_SRC_CTR1  = 4'h9,
    GLF_SRC_LB0   = 4'ha,
    GLF_SRC_LB1   = 4'hb,
    GLF_SRC_EXPO  = 4'hc,
    GLF_SRC_FTW   = 4'hd,
    GLF_SRC_OFF   = 4'hf
  } glf_src_t;

  typedef enum logic [1:0] {
    GLF_FMT_TRI   = 2'h0,
    GLF_FMT_OPTO  = 2'h1,
    GLF_FMT_ODRN  = 2'h2
  } glf_circuit_t;

  typedef struct packed {
    logic [1:0] ctr_active;
    logic [1:0] lb_out;
    logic       expo_active;
    logic       frame_trig_wait;
  } glf_ext_src_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } glf_reg_req_t;

endpackage

// ---- src/glf_line_filter.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "glf_consts.svh"

module glf_line_filter
#(
  parameter int SPAN_W  = `GLF_SPAN_W,
  parameter int CLK_MHZ = `GLF_CLK_MHZ
)
(
  input  wire logic              sys_clk,
  input  wire logic              sys_rst,
  input  wire logic              sys_ce,
  input  wire logic              raw_level,
  input  wire logic [SPAN_W-1:0] dg_span_us,
  input  wire logic [SPAN_W-1:0] db_span_us,
  output logic                   filt_level
);
  import glf_pkg::*;

  localparam int CNT_W = SPAN_W + 7;

  typedef struct packed {
    logic             dg;
    logic             db;
    logic [CNT_W-1:0] dg_cnt;
    logic [CNT_W-1:0] db_cnt;
  } glf_flt_st_t;

  glf_flt_st_t st_reg;
  glf_flt_st_t st_next;
  logic [CNT_W-1:0] dg_cycles;
  logic [CNT_W-1:0] db_cycles;

  function automatic logic [CNT_W-1:0] us_to_cycles(
    input logic [SPAN_W-1:0] us
  );
    logic [CNT_W-1:0] c;
    c = CNT_W'(us) * CNT_W'(CLK_MHZ);
    return (c == '0) ? CNT_W'(1) : c;
  endfunction

  assign dg_cycles = us_to_cycles(dg_span_us);
  assign db_cycles = us_to_cycles(db_span_us);

  always_comb
  begin
    st_next = st_reg;
    if (sys_ce)
    begin
      // deglitch first, debounce on its result
      if (raw_level == st_reg.dg)
        st_next.dg_cnt = '0;
      else if (st_reg.dg_cnt + CNT_W'(1) >= dg_cycles)
      begin
        st_next.dg     = raw_level;
        st_next.dg_cnt = '0;
      end
      else
        st_next.dg_cnt = st_reg.dg_cnt + CNT_W'(1);
      if (st_reg.db_cnt != '0)
        st_next.db_cnt = st_reg.db_cnt - CNT_W'(1);
      else if (st_reg.dg != st_reg.db)
      begin
        st_next.db     = st_reg.dg;
        st_next.db_cnt = db_cycles;
      end
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign filt_level = st_reg.db;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_deglitch_wait:
    assert property ($changed(st_reg.dg) |->
                     $past(st_reg.dg_cnt) + CNT_W'(1) >= $past(dg_cycles))
    else $error("deglitch level moved before its width ran out");

  a_debounce_hold:
    assert property ($changed(st_reg.db) |->
                     $past(st_reg.db_cnt) == '0 && st_reg.db_cnt != '0)
    else $error("debounce output moved while still blocked");

endmodule
`default_nettype wire

// ---- verif/glf_line_partner.sv ----
`timescale 1ns/10ps
`default_nettype none

// outside world on the four lines: a driven pin reads back its own level,
// an undriven one shows what the external switch or driver applies
module glf_line_partner
(
  input  wire logic [3:0] sw_level,
  input  wire logic [3:0] line_out,
  input  wire logic [3:0] line_oe,
  output logic [3:0]      line_in
);
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      line_in[i] = line_oe[i] ? line_out[i] : sw_level[i];
    // open-drain pin: pull-up resistor, switch to ground or device pulls low
    line_in[2] = sw_level[2] & ~line_oe[2];
  end
endmodule

`default_nettype wire

// ---- verif/glf_gpio_top_tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none

module glf_gpio_top_tb_top;
  import glf_pkg::*;
  logic          sys_clk;
  logic          sys_rst;
  logic          sys_ce;
  glf_reg_req_t  reg_req;
  logic [31:0]   reg_rdata;
  glf_ext_src_t  ext_src;
  logic [3:0]    sw_level;
  logic [3:0]    line_in;
  logic [3:0]    line_out;
  logic [3:0]    line_oe;
  logic          aux_supply_on;
  logic [31:0]   exp_q[$];
  logic          rd_q;
  int            errors;
  int            check_count;
  int            seed;
  logic [31:0]   r;
  logic [1:0]    fmt [4];

  glf_gpio_top dut
  (
    .sys_clk       (sys_clk),
    .sys_rst       (sys_rst),
    .sys_ce        (sys_ce),
    .reg_req       (reg_req),
    .reg_rdata     (reg_rdata),
    .ext_src       (ext_src),
    .line_in       (line_in),
    .line_out      (line_out),
    .line_oe       (line_oe),
    .aux_supply_on (aux_supply_on)
  );

  glf_line_partner partner
  (
    .sw_level (sw_level),
    .line_out (line_out),
    .line_oe  (line_oe),
    .line_in  (line_in)
  );

  always #12.5 sys_clk = ~sys_clk;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask

  // expected read data goes in the queue; the monitor pairs it with rdata
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(exp);
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
  endtask

  function automatic logic src_val(input logic [3:0] c);
    case (c)
      4'h8: return ext_src.ctr_active[0];
      4'h9: return ext_src.ctr_active[1];
      4'ha: return ext_src.lb_out[0];
      4'hb: return ext_src.lb_out[1];
      4'hc: return ext_src.expo_active;
      default: return ext_src.frame_trig_wait;
    endcase
  endfunction

  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk)
  begin
    rd_q <= reg_req.rd & sys_ce & ~sys_rst;
    if (rd_q)
    begin
      if (exp_q.size() == 0)
      begin
        errors++;
        $display("ERROR at %0t: read data with no expectation", $time);
      end
      else
        check(reg_rdata, exp_q.pop_front());
    end
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    errors++;
    $display("ERROR at %0t: run did not finish in time", $time);
    print_verdict();
  end

  initial
  begin
    sys_clk = 1'b0;
    sys_rst = 1'b1;
    sys_ce = 1'b1;
    reg_req = '0;
    ext_src = '0;
    sw_level = 4'h0;
    rd_q = 1'b0;
    errors = 0;
    check_count = 0;
    seed = 32'h54fb8d8a;
    fmt = '{2'h1, 2'h1, 2'h2, 2'h0};
    repeat (12) @(posedge sys_clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      wr(8'h00, 32'(i));
      rd(8'h24, 32'(fmt[i]));
    end
    rd(8'h14, 32'h0);
    rd(8'h30, 32'h0);
    wr(8'h20, 32'h5);
    rd(8'h20, 32'h5);
    wr(8'h18, 32'h1);
    wr(8'h1c, 32'h1);
    rd(8'h20, 32'h7);
    rd(8'h1c, 32'h1);
    // a frozen block ignores the write strobe
    sys_ce <= 1'b0;
    wr(8'h20, 32'ha);
    sys_ce <= 1'b1;
    rd(8'h20, 32'h7);
    // deglitch 1 us on line 0: 40 cycles at 40 MHz
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h0c, 32'h1);
    rd(8'h0c, 32'h1);
    sw_level[0] <= 1'b1;
    repeat (20) @(posedge sys_clk);
    sw_level[0] <= 1'b0;
    repeat (60) @(posedge sys_clk);
    rd(8'h14, 32'h0);
    sw_level[0] <= 1'b1;
    repeat (30) @(posedge sys_clk);
    rd(8'h14, 32'h0);
    repeat (20) @(posedge sys_clk);
    rd(8'h14, 32'h1);
    wr(8'h04, 32'h2);
    rd(8'h10, 32'h0);
    rd(8'h04, 32'h2);
    // debounce 1 us on line 3: first edge fast, then 40 cycles locked
    wr(8'h00, 32'h3);
    wr(8'h08, 32'h1);
    wr(8'h0c, 32'h1);
    sw_level[3] <= 1'b1;
    repeat (6) @(posedge sys_clk);
    rd(8'h14, 32'h8);
    sw_level[3] <= 1'b0;
    repeat (10) @(posedge sys_clk);
    rd(8'h14, 32'h8);
    repeat (50) @(posedge sys_clk);
    rd(8'h14, 32'h0);
    // line 1 as output, soft bit 0 first, then every outside source
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h41);
    repeat (2) @(posedge sys_clk);
    check(32'(line_oe[1]), 32'h1);
    check(32'(line_out[1]), 32'h1);
    for (int c = 8; c < 14; c++)
    begin
      r = $random(seed);
      ext_src <= r[5:0];
      wr(8'h04, {24'h0, 4'(c), 4'h1});
      repeat (2) @(posedge sys_clk);
      check(32'(line_out[1]), 32'(src_val(4'(c))));
      wr(8'h04, {24'h0, 4'(c), 4'h3});
      repeat (2) @(posedge sys_clk);
      check(32'(line_out[1]), 32'(!src_val(4'(c))));
    end
    check(32'(line_out[2]), 32'h0);
    // supply enable exists on line 2 only
    wr(8'h00, 32'h2);
    wr(8'h04, 32'h4);
    repeat (2) @(posedge sys_clk);
    check(32'(aux_supply_on), 32'h1);
    rd(8'h04, 32'h4);
    wr(8'h00, 32'h0);
    wr(8'h04, 32'h4);
    rd(8'h04, 32'h0);
    repeat (3) @(posedge sys_clk);
    check(32'(aux_supply_on), 32'h1);
    // open-drain line 2 pulls low only, never while it feeds the supply
    sw_level[2] <= 1'b1;
    wr(8'h00, 32'h2);
    wr(8'h20, 32'h0);
    wr(8'h04, 32'h65);
    repeat (2) @(posedge sys_clk);
    check(32'(line_oe[2]), 32'h0);
    wr(8'h04, 32'h61);
    repeat (2) @(posedge sys_clk);
    check(32'(line_oe[2]), 32'h1);
    check(32'(line_in[2]), 32'h0);
    check(32'(aux_supply_on), 32'h0);
    rd(8'h10, 32'h0);
    wr(8'h20, 32'h4);
    repeat (2) @(posedge sys_clk);
    check(32'(line_oe[2]), 32'h0);
    check(32'(line_in[2]), 32'h1);
    rd(8'h10, 32'h1);
    // line 3 loops back line 0, so it follows line 0's filtered input
    wr(8'h00, 32'h3);
    wr(8'h04, 32'h1);
    repeat (2) @(posedge sys_clk);
    check(32'(line_out[3]), 32'h1);
    sw_level[0] <= 1'b0;
    repeat (30) @(posedge sys_clk);
    check(32'(line_out[3]), 32'h1);
    repeat (30) @(posedge sys_clk);
    check(32'(line_out[3]), 32'h0);
    if (exp_q.size() != 0)
    begin
      errors++;
      $display("ERROR at %0t: expected reads never answered", $time);
    end
    print_verdict();
  end
endmodule

`default_nettype wire
